// file: hw/wda_pkg.sv
// Purpose: shared constants for the receive defect and alarm block
// Assumes: 100 MHz receive clock
// Notes:   byte offsets of the Avalon-MM register words
`default_nettype none
package wda_pkg;
    localparam int CLK_MHZ     = 100;
    localparam int LOF_SET_US  = 3000;
    localparam int LOF_CLR_US  = 1000;
    localparam int LOF_SET_CYC = LOF_SET_US * CLK_MHZ;
    localparam int LOF_CLR_CYC = LOF_CLR_US * CLK_MHZ;
    localparam int LOF_W       = 20;

    // condition bit positions
    localparam int NCOND   = 12;
    localparam int C_LOS   = 0;
    localparam int C_SEF   = 1;
    localparam int C_LOF   = 2;
    localparam int C_B1    = 3;
    localparam int C_B2    = 4;
    localparam int C_B3    = 5;
    localparam int C_REIL  = 6;
    localparam int C_REILC = 7;
    localparam int C_RDIL  = 8;
    localparam int C_REIP  = 9;
    localparam int C_REIPC = 10;
    localparam int C_UNEQ  = 11;
    localparam logic [NCOND-1:0] SQ_KEEP = 12'h007;

    // counter slots
    localparam int NCNT   = 5;
    localparam int K_B1   = 0;
    localparam int K_B2   = 1;
    localparam int K_B3   = 2;
    localparam int K_REIL = 3;
    localparam int K_REIP = 4;

    // register byte offsets
    localparam logic [5:0] A_STAT  = 6'h00;
    localparam logic [5:0] A_PEND  = 6'h04;
    localparam logic [5:0] A_MASKA = 6'h08;
    localparam logic [5:0] A_MASKB = 6'h0c;
    localparam logic [5:0] A_FORCE = 6'h10;
    localparam logic [5:0] A_CTRL  = 6'h14;
    localparam logic [5:0] A_CNT0  = 6'h18;

    // control fields and reset values
    localparam int CTL_W     = 7;
    localparam int CTL_G0    = 3;
    localparam int CTL_G1    = 5;
    localparam logic [CTL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [NCOND-1:0] MASK_RST = 12'h000;

    typedef enum logic [1:0] {GP_OFF, GP_IRQA, GP_IRQB, GP_LOW} wda_gsel_t;
endpackage
`default_nettype wire

// file: hw/wda_cnt_if.sv
// Purpose: carrier between the alarm block and one error counter
// Assumes: single clock domain
// Notes:   ctl side drives increments, cnt side returns the held count
`default_nettype none
interface wda_cnt_if #(
    parameter int INC_W = 11,
    parameter int CNT_W = 32
);
    logic             frame_stb;
    logic             tick;
    logic             blk_mode;
    logic [INC_W-1:0] inc;
    logic [CNT_W-1:0] held;
    modport ctl (output frame_stb, output tick, output blk_mode, output inc, input held);
    modport cnt (input frame_stb, input tick, input blk_mode, input inc, output held);
endinterface
`default_nettype wire

// file: hw/wda_err_counter.sv
// Purpose: saturating error counter with periodic snapshot
// Assumes: increments arrive with the frame strobe
// Notes:   held value is the count of the last tick interval
`default_nettype none
module wda_err_counter #(
    parameter int INC_W = 11,
    parameter int CNT_W = 32
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // counter carrier
    wda_cnt_if.cnt    cif
);
    typedef struct packed {
        logic [CNT_W-1:0] run;
        logic [CNT_W-1:0] held;
    } wda_cst_t;

    wda_cst_t         st_ff;
    wda_cst_t         nxt_st;
    logic [CNT_W:0]   step;
    logic [CNT_W:0]   sum;

    if (INC_W >= CNT_W || CNT_W < 2)
    begin : g_bad
        $error("counter width must exceed increment width");
    end

    always_comb
    begin
        nxt_st = st_ff;
        step   = '0;
        if (cif.frame_stb)
        begin
            if (cif.blk_mode)
                step = (CNT_W+1)'(|cif.inc);
            else
                step = (CNT_W+1)'(cif.inc);
        end
        sum = {1'b0, st_ff.run} + step;
        if (cif.tick)
        begin
            nxt_st.held = st_ff.run;
            nxt_st.run  = step[CNT_W-1:0];
        end
        else if (sum[CNT_W])
            nxt_st.run = '1;
        else
            nxt_st.run = sum[CNT_W-1:0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign cif.held = st_ff.held;

    chk_cnt_saturate: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.run == '1 && !cif.tick) |=> st_ff.run == '1)
        else $error("error counter wrapped");

    chk_blk_step: assert property (@(posedge clk) disable iff (sys_rst)
        (cif.frame_stb && cif.blk_mode && !cif.tick && st_ff.run != '1)
        |=> st_ff.run == $past(st_ff.run) + CNT_W'(|$past(cif.inc)))
        else $error("block mode step is not one per frame");
endmodule
`default_nettype wire

// file: hw/wda_defect_alarm.sv
// Purpose: receive defect and anomaly status, pending and interrupt routing
// Assumes: all receive inputs are on clk; Avalon-MM slave with waitrequest
// Notes:   each access answers with waitrequest low on the second edge
`default_nettype none

// Notes on behaviour
// - loss of signal holds the frame aligner in reset
// - severely errored frame is set whenever framing is not synchronised
// - loss of frame after 3 ms of errored frame, clears after 1 ms clean
// - section parity counter nonzero raises a near-end section anomaly
// - line parity counter nonzero raises line anomaly and its status bit
// - path parity counter nonzero raises a near-end path anomaly
// - nonzero line remote error octet flags a far-end line anomaly
// - nonzero path remote error octet flags a far-end path anomaly
// - line remote defect is detected and shown as a live status bit
// - every condition has status, pending and two mask bits
// - counter conditions rise when the tick snapshot becomes nonzero
// - pending reaches output a or b only through its mask bit
// - status follows the condition live and never latches
// - pending sets on any change of status, either direction
// - higher order defects squelch the lower order alarms
// - interrupts leave only through shared general purpose pins
// - each condition can be forced and masked by software
// - pending holds until software reads it; the read clears it
// - block mode counts once per errored frame, else once per bit
// - tick counters saturate instead of wrapping
module wda_defect_alarm
    import wda_pkg::*;
#(
    parameter int LOF_SET = LOF_SET_CYC,
    parameter int LOF_CLR = LOF_CLR_CYC,
    parameter int INC_W   = 11,
    parameter int CNT_W   = 32
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // avalon-mm slave
    input  wire logic [5:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // receive monitors
    input  wire logic              pma_los,
    input  wire logic              frame_in_sync,
    input  wire logic              rx_frame_stb,
    input  wire logic [3:0]        b1_mis_cnt,
    input  wire logic [INC_W-1:0]  b2_mis_cnt,
    input  wire logic [3:0]        b3_mis_cnt,
    input  wire logic [7:0]        rei_l_octet,
    input  wire logic [7:0]        rei_p_octet,
    input  wire logic              rdi_l_in,
    input  wire logic              uneq_p_in,
    input  wire logic              periodic_monitor_tick,
    // framer and pins
    output logic                   framer_rst,
    output logic      [1:0]        gpio_out,
    output logic      [1:0]        gpio_oe
);
    typedef struct packed {
        logic [NCOND-1:0] stat;
        logic [NCOND-1:0] pend;
        logic [NCOND-1:0] mask_a;
        logic [NCOND-1:0] mask_b;
        logic [NCOND-1:0] force_v;
        logic [CTL_W-1:0] ctrl;
        logic             lof;
        logic [LOF_W-1:0] lcnt;
        logic             alarm_irq_out_a;
        logic             alarm_irq_out_b;
        logic             frst;
        logic [1:0]       gout;
        logic [1:0]       goe;
        logic             wreq;
        logic [31:0]      rdata;
    } wda_st_t;

    localparam wda_st_t ST_RST = '{wreq: 1'b1, ctrl: CTRL_RST, mask_a: MASK_RST,
                                   mask_b: MASK_RST, default: '0};

    wda_st_t          st_ff;
    wda_st_t          nxt_st;
    logic [INC_W-1:0] inc_v  [NCNT];
    logic [CNT_W-1:0] held_v [NCNT];
    logic [NCOND-1:0] raw;
    logic [NCOND-1:0] det;
    logic             hi_order;
    logic             req;
    logic             done;
    logic             rc_hit;
    logic [31:0]      rd_mux;
    wda_gsel_t        gsel [2];

    if (LOF_SET < 1 || LOF_CLR < 1 || LOF_SET >= 2**LOF_W || LOF_CLR >= 2**LOF_W)
    begin : g_bad_lof
        $error("loss of frame counts out of range");
    end
    if (INC_W < 11 || CNT_W < 32)
    begin : g_bad_cnt
        $error("counter widths too small");
    end

    assign inc_v[K_B1]   = INC_W'(b1_mis_cnt);
    assign inc_v[K_B2]   = b2_mis_cnt;
    assign inc_v[K_B3]   = INC_W'(b3_mis_cnt);
    assign inc_v[K_REIL] = INC_W'(rei_l_octet);
    assign inc_v[K_REIP] = INC_W'(rei_p_octet);

    // one saturating counter per parity and remote error source
    for (genvar k = 0; k < NCNT; k++)
    begin : g_cnt
        wda_cnt_if #(.INC_W(INC_W), .CNT_W(CNT_W)) cif ();
        assign cif.frame_stb = rx_frame_stb;
        assign cif.tick      = periodic_monitor_tick;
        assign cif.blk_mode  = (k < 3) ? st_ff.ctrl[k] : 1'b0;
        assign cif.inc       = inc_v[k];
        assign held_v[k]     = cif.held;
        wda_err_counter #(.INC_W(INC_W), .CNT_W(CNT_W)) u_cnt (
            .clk     (clk),
            .sys_rst (sys_rst),
            .cif     (cif.cnt)
        );
    end

    // raw detection
    always_comb
    begin
        raw          = '0;
        raw[C_LOS]   = pma_los;
        raw[C_SEF]   = !frame_in_sync;
        raw[C_LOF]   = st_ff.lof;
        raw[C_B1]    = |held_v[K_B1];
        raw[C_B2]    = |held_v[K_B2];
        raw[C_B3]    = |held_v[K_B3];
        raw[C_REIL]  = |rei_l_octet;
        raw[C_REILC] = |held_v[K_REIL];
        raw[C_RDIL]  = rdi_l_in;
        raw[C_REIP]  = |rei_p_octet;
        raw[C_REIPC] = |held_v[K_REIP];
        raw[C_UNEQ]  = uneq_p_in;
        det          = raw | st_ff.force_v;
        hi_order     = det[C_LOS] | det[C_LOF];
    end

    // register read mux
    always_comb
    begin
        rd_mux = '0;
        unique case (avs_address)
            A_STAT:  rd_mux = 32'({st_ff.alarm_irq_out_b, st_ff.alarm_irq_out_a, st_ff.stat});
            A_PEND:  rd_mux = 32'(st_ff.pend);
            A_MASKA: rd_mux = 32'(st_ff.mask_a);
            A_MASKB: rd_mux = 32'(st_ff.mask_b);
            A_FORCE: rd_mux = 32'(st_ff.force_v);
            A_CTRL:  rd_mux = 32'(st_ff.ctrl);
            default:
            begin
                for (int k = 0; k < NCNT; k++)
                begin
                    if (avs_address == A_CNT0 + 6'(4 * k))
                        rd_mux = 32'(held_v[k]);
                end
            end
        endcase
    end

    assign req    = avs_read | avs_write;
    assign done   = req & ~st_ff.wreq;
    assign rc_hit = done & avs_read & (avs_address == A_PEND);

    always_comb
    begin
        nxt_st = st_ff;

        // bus handshake: capture on first edge, complete on second
        nxt_st.wreq = 1'b1;
        if (req && st_ff.wreq)
        begin
            nxt_st.wreq  = 1'b0;
            nxt_st.rdata = rd_mux;
        end
        if (done && avs_write)
        begin
            unique case (avs_address)
                A_MASKA: nxt_st.mask_a  = avs_writedata[NCOND-1:0];
                A_MASKB: nxt_st.mask_b  = avs_writedata[NCOND-1:0];
                A_FORCE: nxt_st.force_v = avs_writedata[NCOND-1:0];
                A_CTRL:  nxt_st.ctrl    = avs_writedata[CTL_W-1:0];
                default: nxt_st.ctrl    = st_ff.ctrl;
            endcase
        end

        // loss of frame persistence timing
        if (!st_ff.lof)
        begin
            if (det[C_SEF])
            begin
                if (st_ff.lcnt >= LOF_W'(LOF_SET - 1))
                begin
                    nxt_st.lof  = 1'b1;
                    nxt_st.lcnt = '0;
                end
                else
                    nxt_st.lcnt = st_ff.lcnt + 1'b1;
            end
            else
                nxt_st.lcnt = '0;
        end
        else
        begin
            if (!det[C_SEF])
            begin
                if (st_ff.lcnt >= LOF_W'(LOF_CLR - 1))
                begin
                    nxt_st.lof  = 1'b0;
                    nxt_st.lcnt = '0;
                end
                else
                    nxt_st.lcnt = st_ff.lcnt + 1'b1;
            end
            else
                nxt_st.lcnt = '0;
        end

        // live status with hierarchy squelch
        nxt_st.stat = hi_order ? (det & SQ_KEEP) : det;

        // pending: read clears what was returned, a new change wins
        nxt_st.pend = st_ff.pend;
        if (rc_hit)
            nxt_st.pend = st_ff.pend & ~st_ff.rdata[NCOND-1:0];
        nxt_st.pend = nxt_st.pend | (nxt_st.stat ^ st_ff.stat);

        nxt_st.alarm_irq_out_a = |(nxt_st.pend & nxt_st.mask_a);
        nxt_st.alarm_irq_out_b = |(nxt_st.pend & nxt_st.mask_b);

        nxt_st.frst = det[C_LOS];

        // shared pin function select
        gsel[0] = wda_gsel_t'(nxt_st.ctrl[CTL_G0 +: 2]);
        gsel[1] = wda_gsel_t'(nxt_st.ctrl[CTL_G1 +: 2]);
        for (int p = 0; p < 2; p++)
        begin
            unique case (gsel[p])
                GP_OFF:
                begin
                    nxt_st.gout[p] = 1'b0;
                    nxt_st.goe[p]  = 1'b0;
                end
                GP_IRQA:
                begin
                    nxt_st.gout[p] = nxt_st.alarm_irq_out_a;
                    nxt_st.goe[p]  = 1'b1;
                end
                GP_IRQB:
                begin
                    nxt_st.gout[p] = nxt_st.alarm_irq_out_b;
                    nxt_st.goe[p]  = 1'b1;
                end
                GP_LOW:
                begin
                    nxt_st.gout[p] = 1'b0;
                    nxt_st.goe[p]  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = st_ff.wreq;
    assign framer_rst      = st_ff.frst;
    assign gpio_out        = st_ff.gout;
    assign gpio_oe         = st_ff.goe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_framer_hold: assert property (
        (pma_los || st_ff.force_v[C_LOS]) |=> framer_rst)
        else $error("framer not held in reset on loss of signal");

    chk_sef_sync: assert property (
        !frame_in_sync |=> st_ff.stat[C_SEF])
        else $error("errored frame not shown while out of sync");

    chk_lof_set: assert property (
        $rose(st_ff.lof) |-> $past(st_ff.lcnt) == LOF_W'(LOF_SET - 1) && $past(det[C_SEF]))
        else $error("loss of frame declared at wrong time");

    chk_lof_clear: assert property (
        $fell(st_ff.lof) |-> $past(st_ff.lcnt) == LOF_W'(LOF_CLR - 1) && !$past(det[C_SEF]))
        else $error("loss of frame cleared at wrong time");

    chk_line_nonzero: assert property (
        (|held_v[K_B2]) |=> st_ff.stat[C_B2] || st_ff.stat[C_LOS] || st_ff.stat[C_LOF])
        else $error("line counter nonzero not shown");

    chk_reil_octet: assert property (
        (|rei_l_octet) |=> st_ff.stat[C_REIL] || st_ff.stat[C_LOS] || st_ff.stat[C_LOF])
        else $error("remote line error octet not flagged");

    chk_squelch_low: assert property (
        (st_ff.stat[C_LOS] || st_ff.stat[C_LOF]) |-> (st_ff.stat & ~SQ_KEEP) == '0)
        else $error("lower order alarm not squelched");

    chk_pend_change: assert property (
        ((st_ff.stat ^ $past(st_ff.stat)) & ~st_ff.pend) == '0)
        else $error("status change did not set pending");

    chk_pend_hold: assert property (
        (|($past(st_ff.pend) & ~st_ff.pend)) |-> $past(rc_hit))
        else $error("pending cleared without a read");

    chk_irq_level: assert property (
        st_ff.alarm_irq_out_a == |(st_ff.pend & st_ff.mask_a)
        && st_ff.alarm_irq_out_b == |(st_ff.pend & st_ff.mask_b))
        else $error("interrupt level disagrees with masked pending");

    chk_gpio_route: assert property (
        (st_ff.ctrl[CTL_G0 +: 2] == 2'h1) |-> gpio_oe[0] && gpio_out[0] == st_ff.alarm_irq_out_a)
        else $error("pin 0 does not carry interrupt a");

    chk_gpio_route_b: assert property (
        (st_ff.ctrl[CTL_G1 +: 2] == 2'h2) |-> gpio_oe[1] && gpio_out[1] == st_ff.alarm_irq_out_b)
        else $error("pin 1 does not carry interrupt b");

    chk_status_live: assert property (
        !$past(sys_rst) && !$past(hi_order) |-> st_ff.stat == $past(det))
        else $error("status does not follow the live condition");

    chk_bus_answer: assert property (
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// file: test/wda_host_model.sv
// Purpose: management host model, Avalon-MM master polling the alarm block
// Assumes: one request outstanding, signals change just after the rising edge
// Notes:   stall_cnt counts accesses not answered on the second edge
`default_nettype none
module wda_host_model (
    // clock
    input  wire logic        clk,
    // avalon-mm master
    output var logic  [5:0]  avs_address,
    output var logic         avs_read,
    output var logic         avs_write,
    output var logic  [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;

    int stall_cnt = 0;

    initial
    begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end

    // hold the request until waitrequest is sampled low, then release
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        if (n != 2)
            stall_cnt++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: self-checking bench for the receive defect and alarm block
// Assumes: short loss-of-frame timing, LOF_SET 20 and LOF_CLR 8 cycles
// Notes:   expected values come from a small model of the conditions
`default_nettype none
module tb
    import wda_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        pma_los, frame_in_sync, rx_frame_stb, rdi_l_in, uneq_p_in;
    logic        periodic_monitor_tick, framer_rst;
    logic [3:0]  b1_mis_cnt, b3_mis_cnt;
    logic [10:0] b2_mis_cnt;
    logic [7:0]  rei_l_octet, rei_p_octet;
    logic [1:0]  gpio_out, gpio_oe;
    logic [11:0] ma, mb;
    int          err_total, cmp_count;
    int          cnt[NCNT];

    wda_defect_alarm #(.LOF_SET(20), .LOF_CLR(8)) wda_defect_alarm_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pma_los(pma_los), .frame_in_sync(frame_in_sync),
        .rx_frame_stb(rx_frame_stb), .b1_mis_cnt(b1_mis_cnt), .b2_mis_cnt(b2_mis_cnt),
        .b3_mis_cnt(b3_mis_cnt), .rei_l_octet(rei_l_octet), .rei_p_octet(rei_p_octet),
        .rdi_l_in(rdi_l_in), .uneq_p_in(uneq_p_in),
        .periodic_monitor_tick(periodic_monitor_tick), .framer_rst(framer_rst),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));

    wda_host_model wda_host_model_inst (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        wda_host_model_inst.xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        wda_host_model_inst.xfer(1'b0, a, 32'h0, d);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    initial
    begin
        logic [3:0]  v1, v3;
        logic [10:0] v2;
        logic [7:0]  v4, v5;
        logic [2:0]  blk;
        void'($urandom(32'hf4cc1cc4));
        err_total = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        {pma_los, rx_frame_stb, rdi_l_in, uneq_p_in, periodic_monitor_tick} = 5'h00;
        frame_in_sync = 1'b1;
        {b1_mis_cnt, b3_mis_cnt, b2_mis_cnt, rei_l_octet, rei_p_octet} = 35'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values and address decode
        rd(A_MASKA, q);
        chk("mask a reset", 32'h0, q);
        rd(A_CTRL, q);
        chk("ctrl reset", 32'h0, q);
        rd(6'h2c, q);
        chk("unmapped read", 32'h0, q);
        ma = 12'($urandom);
        mb = 12'($urandom);
        wr(A_MASKA, {20'h0, ma});
        wr(A_MASKB, {20'h0, mb});
        wr(A_CTRL, 32'h48);
        rd(A_MASKA, q);
        chk("mask a", {20'h0, ma}, q);
        rd(A_PEND, q);
        // force each condition in turn
        for (int i = 0; i < NCOND; i++)
        begin
            wr(A_FORCE, 32'h1 << i);
            idle(4);
            chk("gpio out", {30'h0, mb[i], ma[i]}, {30'h0, gpio_out});
            chk("gpio oe", 32'h3, {30'h0, gpio_oe});
            chk("framer reset", 32'(i == 0), {31'h0, framer_rst});
            rd(A_STAT, q);
            chk("status", (32'h1 << i) | {18'h0, mb[i], ma[i], 12'h0}, q);
            rd(A_PEND, q);
            chk("pending rise", 32'h1 << i, q);
            rd(A_STAT, q);
            chk("irq after read", 32'h1 << i, q);
            wr(A_FORCE, 32'h0);
            idle(3);
            rd(A_PEND, q);
            chk("pending fall", 32'h1 << i, q);
        end
        wr(A_CTRL, 32'h18);
        idle(3);
        chk("pin drive low", 32'h2, {29'h0, gpio_oe, gpio_out[0]});
        // detected defects and squelch
        rdi_l_in <= 1'b1;
        uneq_p_in <= 1'b1;
        idle(3);
        rd(A_STAT, q);
        chk("remote defect", 32'h900, q & 32'hfff);
        pma_los <= 1'b1;
        idle(3);
        chk("framer hold", 32'h1, {31'h0, framer_rst});
        rd(A_STAT, q);
        chk("squelch", 32'h1, q & 32'hfff);
        pma_los <= 1'b0;
        rdi_l_in <= 1'b0;
        uneq_p_in <= 1'b0;
        idle(3);
        // loss of frame timing
        frame_in_sync <= 1'b0;
        idle(9);
        rd(A_STAT, q);
        chk("errored frame", 32'h2, q & 32'h7);
        idle(20);
        rd(A_STAT, q);
        chk("frame loss set", 32'h6, q & 32'h7);
        frame_in_sync <= 1'b1;
        idle(2);
        rd(A_STAT, q);
        chk("frame loss hold", 32'h4, q & 32'h7);
        idle(12);
        rd(A_STAT, q);
        chk("frame loss clear", 32'h0, q & 32'h7);
        // error counters
        blk = 3'($urandom);
        wr(A_CTRL, {29'h0, blk});
        cnt = '{default: 0};
        for (int f = 0; f < 6; f++)
        begin
            v1 = 4'($urandom);
            v2 = 11'($urandom);
            v3 = 4'($urandom);
            v4 = 8'($urandom);
            v5 = 8'($urandom);
            cnt[K_B1] += blk[0] ? int'(v1 != 0) : int'(v1);
            cnt[K_B2] += blk[1] ? int'(v2 != 0) : int'(v2);
            cnt[K_B3] += blk[2] ? int'(v3 != 0) : int'(v3);
            cnt[K_REIL] += int'(v4);
            cnt[K_REIP] += int'(v5);
            {b1_mis_cnt, b2_mis_cnt, b3_mis_cnt} <= {v1, v2, v3};
            {rei_l_octet, rei_p_octet} <= {v4, v5};
            rx_frame_stb <= 1'b1;
            @(posedge clk);
            rx_frame_stb <= 1'b0;
            idle(1);
        end
        rd(A_STAT, q);
        chk("remote octets", {22'h0, v5 != 0, 2'h0, v4 != 0, 6'h0}, q & 32'h240);
        {rei_l_octet, rei_p_octet} <= 16'h0;
        periodic_monitor_tick <= 1'b1;
        @(posedge clk);
        periodic_monitor_tick <= 1'b0;
        idle(2);
        for (int k = 0; k < NCNT; k++)
        begin
            rd(A_CNT0 + 6'(4 * k), q);
            chk("held count", 32'(cnt[k]), q);
        end
        rd(A_STAT, q);
        chk("count nonzero", {21'h0, cnt[K_REIP] != 0, 2'h0, cnt[K_REIL] != 0, 1'b0,
            cnt[K_B3] != 0, cnt[K_B2] != 0, cnt[K_B1] != 0, 3'h0}, q & 32'hfff);
        periodic_monitor_tick <= 1'b1;
        @(posedge clk);
        periodic_monitor_tick <= 1'b0;
        idle(2);
        rd(A_STAT, q);
        chk("status drops", 32'h0, q & 32'hfff);
        chk("bus stalls", 32'h0, 32'(wda_host_model_inst.stall_cnt));
        print_verdict();
    end
endmodule
`default_nettype wire
